// file: hdl/sewp_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM write-protect block
// Assumes: Mode 0/3 serial link, 32K x 8 array, 64-byte pages
// Notes: Times are given in their own unit; cycle counts are derived from them
package sewp_pkg;
  // Command opcodes
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  // Block-guard levels and protected range bases
  localparam logic [1:0] GUARD_NONE = 2'h0;
  localparam logic [1:0] GUARD_QUARTER = 2'h1;
  localparam logic [1:0] GUARD_HALF = 2'h2;
  localparam logic [1:0] GUARD_ALL = 2'h3;
  localparam logic [14:0] QUARTER_BASE = 15'h6000;
  localparam logic [14:0] HALF_BASE = 15'h4000;
  // Frame lengths in whole bytes; last bit index within a byte
  localparam logic [6:0] BYTES_CMD = 7'h01;
  localparam logic [6:0] BYTES_STAT = 7'h02;
  localparam logic [6:0] BYTES_HDR = 7'h03;
  localparam logic [6:0] BYTES_MIN_WR = 7'h04;
  localparam logic [6:0] BYTES_SAT = 7'h7F;
  localparam logic [2:0] PHASE_LAST = 3'h7;
  // Status byte field positions
  localparam int SB_BUSY = 0;
  localparam int SB_WEN = 1;
  localparam int SB_GUARD_LO = 2;
  localparam int SB_GUARD_HI = 3;
  localparam int SB_LOCK = 7;
  // Reset values of the protection bits and of the pin synchronisers
  localparam logic [1:0] RST_GUARD = 2'h0;
  localparam logic RST_LOCK = 1'b0;
  localparam logic [2:0] SYNC_RST = 3'h3;
  // Pin index in the synchroniser vector
  localparam int PIN_CS = 0;
  localparam int PIN_WP = 1;
  localparam int PIN_TOG = 2;
  // Timing
  localparam int unsigned MCLK_KHZ = 20000;
  localparam int unsigned PROG_TIME_MS = 10;
  localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_MS * MCLK_KHZ;
  localparam int unsigned PAGE_BYTES = 64;

  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] addr;
    logic [6:0] bytes;
    logic [2:0] phase;
  } sewp_frame_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_PAGE = 2'b01,
    S_STAT = 2'b10
  } sewp_state_t;
endpackage

// file: hdl/sewp_core.sv
// Purpose: Write-side command logic of a serial EEPROM behind a mode 0/3 slave link
// Assumes: i_sck only toggles while i_cs_n is low; host sends only status reads while busy
// Notes: Frame capture runs on i_sck, decode and programming on i_mclk
// Behaviour
// - Guard bits 00 none, 01 6000h-7FFFh, 10 4000h-7FFFh, 11 all; refuse protected writes.
// - Lock bit set with guard pin low ignores status writes entirely.
// - Guard pin high keeps status writable; array range guard always applies.
// - Command 06h sets write latch; latch needed for memory or status write.
// - Command 04h clears write latch until a later 06h.
// - Write frame is 02h, 16-bit address, data until chip select rises; A15 ignored.
// - Write stays in one 64-byte page; only low six address bits advance.
// - Accept 1 to 64 bytes; beyond 64 only the last 64 are programmed.
// - Program only whole bytes; mid-byte chip-select rise aborts with nothing written.
// - Page programming takes at most 10 ms; device busy meanwhile.
// - Discard write command whose chip-select rise is off an 8-clock boundary.
// - Discard status write frame longer than opcode plus one data byte.
// - Hold low with clock low suspends; hold high resumes.
// - Hold acts only with chip select low; chip-select rise resets frame state.
// - Suspended: output high impedance, serial input and clock ignored.
// - Write latch clears at reset and after memory or status write completes.
// - Status bit 0 reads 1 while an internal write is in progress.
`timescale 1ns/1ps
`default_nettype none
module sewp_core
  import sewp_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
)
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  output logic o_so,
  output logic o_so_oe,
  output logic o_busy,
  output logic o_wen,
  output logic [1:0] o_guard,
  output logic o_status_lock,
  output logic o_prog_we,
  output logic [14:0] o_prog_addr,
  output logic [7:0] o_prog_data
);
  localparam int TW = $clog2(PROG_CYCLES);

  // The page walk needs 65 cycles inside the busy window: 64 slots plus the registered write strobe
  if (PROG_CYCLES < PAGE_BYTES + 1)
  begin : g_chk
    $error("PROG_CYCLES too small for the page walk");
  end

  // Link side
  logic frame_rst_n;
  logic in_frame;
  logic frame_tog;
  sewp_frame_t frm;
  logic [7:0] shreg;
  logic [5:0] ptr;
  logic [63:0] lmask;
  logic [7:0] pbuf [0:63];
  logic [7:0] st_l1;
  logic [7:0] st_l2;
  logic [2:0] rd_ph;
  logic rd_on;
  logic first;
  logic [2:0] ph_cur;
  logic [6:0] by_cur;
  logic [7:0] sh_nx;
  logic byte_done;
  logic data_load;

  // Core side
  logic [2:0] pin_raw;
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  logic [2:0] pin_q;
  logic [2:0] pin_ok;
  logic tog_seen;
  sewp_state_t state;
  logic [TW-1:0] timer;
  logic [6:0] idx;
  logic [63:0] pmask;
  logic [8:0] page;
  logic [7:0] sr_new;
  logic [7:0] st_word;
  logic cs_rise;
  logic cmd;
  logic sr_locked;
  logic do_set;
  logic do_clr;
  logic do_sw;
  logic do_pw;
  logic done;

  // Frame state is cleared whenever chip select is high
  assign frame_rst_n = i_nrst & ~i_cs_n;

  // First edge of a frame sees zero counts, so stale results never leak in
  assign first = ~in_frame;
  assign ph_cur = first ? 3'h0 : frm.phase;
  assign by_cur = first ? 7'h00 : frm.bytes;
  assign sh_nx = {shreg[6:0], i_si};
  assign byte_done = (ph_cur == PHASE_LAST);
  assign data_load = byte_done && (by_cur >= BYTES_HDR) && (frm.opcode == OP_PAGE_WRITE);

  // Frame marker, cleared asynchronously by chip select high
  always_ff @(posedge i_sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      in_frame <= 1'b0;
    end
    else if (i_hold_n) // Clock ignored while suspended
    begin
      in_frame <= 1'b1;
    end
  end

  // One toggle per frame tells the core side that a fresh capture exists
  always_ff @(posedge i_sck or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      frame_tog <= 1'b0;
    end
    else if (i_hold_n && first)
    begin
      frame_tog <= ~frame_tog;
    end
  end

  // Capture registers survive chip select high so the core can decode them
  always_ff @(posedge i_sck or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      frm <= '0;
      shreg <= 8'h00;
      ptr <= 6'h00;
      lmask <= '0;
    end
    else if (i_hold_n) // Serial input ignored while suspended
    begin
      shreg <= sh_nx;
      frm.phase <= ph_cur + 3'h1; // Counts bits within the 8-clock bus cycle
      frm.bytes <= byte_done ? ((by_cur == BYTES_SAT) ? by_cur : by_cur + 7'h01) : by_cur;
      if (first)
      begin
        lmask <= '0;
      end
      if (byte_done)
      begin
        case (by_cur)
          7'h00: frm.opcode <= sh_nx;
          7'h01: frm.addr[15:8] <= sh_nx; // Also the status data byte
          7'h02:
          begin
            frm.addr[7:0] <= sh_nx;
            ptr <= sh_nx[5:0];
          end
          default:
          begin
            if (data_load)
            begin
              lmask[ptr] <= 1'b1;
              ptr <= ptr + 6'h01; // Six-bit counter wraps inside the page
            end
          end
        endcase
      end
    end
  end

  // Page buffer: later bytes overwrite earlier ones at the same slot
  always_ff @(posedge i_sck)
  begin
    if (i_hold_n && data_load)
    begin
      pbuf[ptr] <= sh_nx;
    end
  end

  // Status byte brought onto the link clock; two edges stale, which a poll loop tolerates
  always_ff @(posedge i_sck or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_l1 <= 8'h00;
      st_l2 <= 8'h00;
    end
    else
    begin
      st_l1 <= st_word;
      st_l2 <= st_l1;
    end
  end

  // Status read shifts out on falling edges, bit 7 first, repeating
  always_ff @(negedge i_sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      o_so <= 1'b0;
      rd_on <= 1'b0;
      rd_ph <= 3'h0;
    end
    else if (i_hold_n && in_frame && frm.opcode == OP_STATUS_READ && frm.bytes != 7'h00)
    begin
      rd_on <= 1'b1;
      o_so <= st_l2[3'h7 - rd_ph];
      rd_ph <= rd_ph + 3'h1;
    end
  end

  // Output released while suspended or deselected
  assign o_so_oe = rd_on & i_hold_n & ~i_cs_n;

  // Pins and the frame toggle cross on three flops each
  assign pin_raw = {frame_tog, i_wp_n, i_cs_n};
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pin_s1 <= SYNC_RST;
      pin_s2 <= SYNC_RST;
      pin_s3 <= SYNC_RST;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // A change counts once the second and third stage agree
  for (genvar g = 0; g < 3; g++)
  begin : g_pin
    assign pin_ok[g] = (pin_s2[g] == pin_s3[g]);
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
      if (!i_nrst)
      begin
        pin_q[g] <= SYNC_RST[g];
      end
      else if (pin_ok[g])
      begin
        pin_q[g] <= pin_s3[g];
      end
    end
  end

  assign cs_rise = pin_ok[PIN_CS] & pin_s3[PIN_CS] & ~pin_q[PIN_CS];

  // Remember which capture has been consumed
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tog_seen <= 1'b0;
    end
    else if (cs_rise)
    begin
      tog_seen <= pin_q[PIN_TOG];
    end
  end

  // Guarded ranges of the array
  function automatic logic guarded(input logic [1:0] lvl, input logic [14:0] a);
    logic hit;
    hit = 1'b0;
    case (lvl)
      GUARD_NONE: hit = 1'b0;
      GUARD_QUARTER: hit = (a >= QUARTER_BASE);
      GUARD_HALF: hit = (a >= HALF_BASE);
      GUARD_ALL: hit = 1'b1;
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction

  // Decode at the chip-select rise; only whole bytes count
  assign cmd = cs_rise && (pin_q[PIN_TOG] != tog_seen) && (frm.phase == 3'h0) && (state == S_IDLE);
  assign do_set = cmd && frm.bytes == BYTES_CMD && frm.opcode == OP_SET_LATCH;
  assign do_clr = cmd && frm.bytes == BYTES_CMD && frm.opcode == OP_CLR_LATCH;
  assign sr_locked = o_status_lock & ~pin_q[PIN_WP]; // Guard pin high frees the status
  assign do_sw = cmd && frm.bytes == BYTES_STAT && frm.opcode == OP_STATUS_WRITE
    && o_wen && !sr_locked; // Exact length only
  assign do_pw = cmd && frm.bytes >= BYTES_MIN_WR && frm.opcode == OP_PAGE_WRITE
    && o_wen && !guarded(o_guard, frm.addr[14:0]); // A15 dropped
  assign done = (state != S_IDLE) && (timer == TW'(PROG_CYCLES - 1));

  // Write latch
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_wen <= 1'b0;
    end
    else if (done)
    begin
      o_wen <= 1'b0;
    end
    else if (do_set)
    begin
      o_wen <= 1'b1;
    end
    else if (do_clr)
    begin
      o_wen <= 1'b0;
    end
  end

  // Busy sequencer: one timer covers page and status programming
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= S_IDLE;
      timer <= '0;
      pmask <= '0;
      page <= 9'h000;
      sr_new <= 8'h00;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          timer <= '0;
          if (do_pw)
          begin
            state <= S_PAGE;
            pmask <= lmask;
            page <= frm.addr[14:6]; // Page bits stay fixed
          end
          else if (do_sw)
          begin
            state <= S_STAT;
            sr_new <= frm.addr[15:8];
          end
        end
        S_PAGE, S_STAT:
        begin
          timer <= timer + TW'(1); // Busy for the programming window
          if (done)
          begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Protection bits change only when a status write completes
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_guard <= RST_GUARD;
      o_status_lock <= RST_LOCK;
    end
    else if (done && state == S_STAT)
    begin
      o_guard <= {sr_new[SB_GUARD_HI], sr_new[SB_GUARD_LO]};
      o_status_lock <= sr_new[SB_LOCK];
    end
  end

  // Page walk: every slot loaded this frame goes to the array once
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      idx <= 7'h00;
      o_prog_we <= 1'b0;
      o_prog_addr <= 15'h0000;
      o_prog_data <= 8'h00;
    end
    else
    begin
      o_prog_we <= (state == S_PAGE) && !idx[6] && pmask[idx[5:0]];
      o_prog_addr <= {page, idx[5:0]};
      o_prog_data <= pbuf[idx[5:0]];
      if (state == S_PAGE && !idx[6])
      begin
        idx <= idx + 7'h01;
      end
      else if (state == S_IDLE)
      begin
        idx <= 7'h00;
      end
    end
  end

  assign o_busy = (state != S_IDLE);

  // Status byte as seen by a status read
  always_comb
  begin
    st_word = 8'h00;
    st_word[SB_BUSY] = o_busy;
    st_word[SB_WEN] = o_wen;
    st_word[SB_GUARD_LO] = o_guard[0];
    st_word[SB_GUARD_HI] = o_guard[1];
    st_word[SB_LOCK] = o_status_lock;
  end
endmodule
`default_nettype wire

// file: verification/sewp_chk.sv
// Purpose: Port checks for the write-protect core
// Assumes: All checks run in the core clock domain
// Notes: Busy length is counted in helper logic, not unrolled
`timescale 1ns/1ps
`default_nettype none
module sewp_chk
  import sewp_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
)
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic o_busy,
  input wire logic o_wen,
  input wire logic [1:0] o_guard,
  input wire logic o_status_lock,
  input wire logic o_prog_we,
  input wire logic [14:0] o_prog_addr,
  input wire logic [7:0] o_prog_data
);
  logic [31:0] busy_cnt;
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  // Busy cycle count; a wide counter avoids a long repetition
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      busy_cnt <= '0;
    else
      busy_cnt <= o_busy ? busy_cnt + 32'h1 : '0;
  end
  AST_LATCH_BEFORE_WRITE: assert property ($rose(o_busy) |-> o_wen)
    else $error("Busy without write latch");
  AST_LATCH_CLEARED: assert property ($fell(o_busy) |-> !o_wen)
    else $error("Latch not cleared at done");
  AST_BUSY_LENGTH: assert property ($fell(o_busy) |-> busy_cnt == PROG_CYCLES)
    else $error("Busy window length wrong");
  AST_PROG_IN_BUSY: assert property (o_prog_we |-> o_busy)
    else $error("Programming outside busy");
  AST_GUARD_RANGE: assert property (o_prog_we |-> !(o_guard == GUARD_ALL ||
    (o_guard == GUARD_HALF && o_prog_addr >= HALF_BASE) || (o_guard == GUARD_QUARTER && o_prog_addr >= QUARTER_BASE)))
    else $error("Write into guarded range");
  AST_SLOT_STEP: assert property (o_prog_we && $past(o_prog_we) |-> o_prog_addr == $past(o_prog_addr) + 15'h1)
    else $error("Slot step or page change");
  AST_STATUS_AT_DONE: assert property ($changed(o_guard) || $changed(o_status_lock) |-> $fell(o_busy))
    else $error("Status bits moved outside done");
  AST_SO_RELEASED: assert property (i_cs_n || !i_hold_n |-> !o_so_oe)
    else $error("Output driven while held");
  AST_SET_WHEN_IDLE: assert property ($rose(o_wen) |-> !o_busy)
    else $error("Latch set while busy");
endmodule
bind sewp_core sewp_chk #(.PROG_CYCLES(PROG_CYCLES)) u_sewp_chk (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .o_so(o_so),
  .o_so_oe(o_so_oe), .o_busy(o_busy), .o_wen(o_wen), .o_guard(o_guard), .o_status_lock(o_status_lock),
  .o_prog_we(o_prog_we), .o_prog_addr(o_prog_addr), .o_prog_data(o_prog_data));
`default_nettype wire

// file: verification/sewp_host.sv
// Purpose: Behavioural host framing commands on the serial link
// Assumes: Mode 0, link clock idle low, 64 ns period
// Notes: The link clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module sewp_host
(
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  output logic o_hold_n,
  input wire logic i_so,
  input wire logic i_so_oe
);
  logic [7:0] q [$];
  int hold_at = -1;
  logic [7:0] rx = 8'h00;
  logic oe_at = 1'b0;
  // Idle levels; chip select stays high through power-up
  initial
  begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    o_hold_n = 1'b1;
  end
  // Suspends with junk on clock and data; hold moves only with the clock low
  task automatic pause();
    o_hold_n = 1'b0;
    repeat (4)
    begin
      #32 o_sck = ~o_sck;
      o_si = ~o_si;
    end
    #32 o_hold_n = 1'b1;
  endtask
  // MSB first; data changes with the clock low and is taken on its rise
  task automatic frame(input int nbits);
    int i;
    #7 o_cs_n = 1'b0;
    #32;
    for (i = 0; i < nbits; i++)
    begin
      if (i == hold_at)
        pause();
      o_si = q[i / 8][7 - i % 8];
      #32 o_sck = 1'b1;
      rx = {rx[6:0], i_so}; // Read data is settled since the last falling edge
      oe_at = i_so_oe;
      #32 o_sck = 1'b0;
    end
    #32 o_cs_n = 1'b1;
    o_si = ~o_si; // Released line shows no stale level
    #400;
    q.delete();
    hold_at = -1;
  endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
// Purpose: Self-checking bench for the write-protect core
// Assumes: Core built with a short program window
// Notes: Array contents are rebuilt from the programming stream
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sewp_pkg::*;
  localparam int unsigned PC = 100;
  localparam logic [15:0] ADR [3] = '{16'h0000, 16'h4000, 16'h6000};
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b1;
  logic i_wp_n = 1'b1;
  logic sck, cs_n, si, hold_n, so, so_oe, busy, wen, lock, we;
  logic [1:0] guard;
  logic [14:0] paddr;
  logic [7:0] pdata;
  logic [7:0] mem [int];
  int fails = 0;
  int n_compared = 0;
  int n_prog = 0;
  int cyc = 0;
  sewp_core #(.PROG_CYCLES(PC)) u_sewp_core (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_sck(sck), .i_cs_n(cs_n),
    .i_si(si), .i_hold_n(hold_n), .i_wp_n(i_wp_n), .o_so(so), .o_so_oe(so_oe), .o_busy(busy), .o_wen(wen),
    .o_guard(guard), .o_status_lock(lock), .o_prog_we(we), .o_prog_addr(paddr), .o_prog_data(pdata));
  sewp_host u_sewp_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n), .i_so(so),
    .i_so_oe(so_oe));
  always #25 i_mclk = ~i_mclk;
  // Array image from the programming stream; also cuts a hung run short
  always @(posedge i_mclk)
  begin
    cyc++;
    if (we === 1'b1)
    begin
      mem[int'(paddr)] = pdata;
      n_prog++;
    end
    if (cyc == 60000)
    begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One frame, then the decode delay and any programming window
  task automatic send(input int nb, input int extra);
    int k;
    u_sewp_host.frame(8 * nb + extra);
    repeat (8) @(posedge i_mclk);
    #2;
    for (k = 0; k < 300 && busy === 1'b1; k++)
    begin
      @(posedge i_mclk);
      #2;
    end
  endtask
  task automatic one(input logic [7:0] b, input int extra);
    u_sewp_host.q.push_back(b);
    send(1, extra);
  endtask
  // Page write of n bytes 10h, 11h...; one spare byte feeds stray bits
  task automatic pw(input logic [15:0] a, input int n, input int extra);
    mem.delete();
    n_prog = 0;
    u_sewp_host.q = '{OP_PAGE_WRITE, a[15:8], a[7:0]};
    for (int i = 0; i <= n; i++)
      u_sewp_host.q.push_back(8'(i + 16));
    send(3 + n, extra);
  endtask
  // Status read: opcode, then one status byte shifted out on the falling edges
  task automatic rd(input logic [7:0] exp);
    u_sewp_host.q = '{OP_STATUS_READ, 8'h00};
    u_sewp_host.frame(16);
    chk("status", u_sewp_host.rx, 16'(exp));
    chk("so_oe_read", u_sewp_host.oe_at, 16'h1);
    chk("so_oe_idle", so_oe, 16'h0);
  endtask
  task automatic ws(input logic [7:0] d, input int nb);
    u_sewp_host.q.push_back(OP_STATUS_WRITE);
    repeat (nb - 1) u_sewp_host.q.push_back(d);
    send(nb, 0);
  endtask
  task automatic t_latch();
    chk("wen", wen, 16'h0);
    chk("guard", guard, 16'h0);
    one(OP_SET_LATCH, -1);
    chk("wen", wen, 16'h0);
    one(OP_SET_LATCH, 0);
    chk("wen", wen, 16'h1);
    rd(8'h02);
    one(OP_CLR_LATCH, 0);
    chk("wen", wen, 16'h0);
    pw(16'h0040, 2, 0);
    chk("n_prog", n_prog, 16'h0);
    $display("Test latch done");
  endtask
  task automatic t_page();
    one(OP_SET_LATCH, 0);
    pw(16'h803E, 3, 0);
    chk("n_prog", n_prog, 16'h3);
    chk("m3f", mem[32'h3F], 16'h11);
    chk("m00", mem[32'h00], 16'h12);
    chk("wen", wen, 16'h0);
    one(OP_SET_LATCH, 0);
    pw(16'h0100, 66, 0);
    chk("n_prog", n_prog, 16'h40);
    chk("m101", mem[32'h101], 16'h51);
    chk("m102", mem[32'h102], 16'h12);
    one(OP_SET_LATCH, 0);
    pw(16'h0200, 2, 4);
    chk("n_prog", n_prog, 16'h0);
    chk("wen", wen, 16'h1);
    u_sewp_host.hold_at = 12;
    pw(16'h0300, 1, 0);
    chk("m300", mem[32'h300], 16'h10);
    // Status polled while the page is still being programmed
    one(OP_SET_LATCH, 0);
    u_sewp_host.q = '{OP_PAGE_WRITE, 8'h04, 8'h00, 8'h5A};
    u_sewp_host.frame(32);
    rd(8'h03);
    chk("busy", busy, 16'h1);
    repeat (100) @(posedge i_mclk);
    #2;
    chk("busy", busy, 16'h0);
    rd(8'h00);
    $display("Test page done");
  endtask
  task automatic t_guard();
    for (int g = 0; g < 4; g++)
    begin
      one(OP_SET_LATCH, 0);
      ws(8'(g * 4), 2);
      chk("guard", guard, 16'(g));
      for (int a = 0; a < 3; a++)
      begin
        one(OP_SET_LATCH, 0);
        pw(ADR[a], 1, 0);
        chk("n_prog", n_prog, (g == 3 || (g == 2 && a > 0) || (g == 1 && a == 2)) ? 16'h0 : 16'h1);
      end
    end
    $display("Test guard done");
  endtask
  task automatic t_lock();
    one(OP_SET_LATCH, 0);
    ws(8'h8C, 2);
    chk("lock", lock, 16'h1);
    chk("guard", guard, 16'h3);
    @(posedge i_mclk);
    #2 i_wp_n = 1'b0;
    one(OP_SET_LATCH, 0);
    ws(8'h00, 2);
    chk("lock", lock, 16'h1);
    chk("guard", guard, 16'h3);
    @(posedge i_mclk);
    #2 i_wp_n = 1'b1;
    ws(8'h00, 3);
    chk("guard", guard, 16'h3);
    ws(8'h00, 2);
    chk("lock", lock, 16'h0);
    chk("guard", guard, 16'h0);
    $display("Test lock done");
  endtask
  initial
  begin
    #2 i_nrst = 1'b0; // A real falling edge also resets the link-side flops
    repeat (3) @(posedge i_mclk);
    #2 i_nrst = 1'b1;
    repeat (5) @(posedge i_mclk);
    t_latch();
    t_page();
    t_guard();
    t_lock();
    stop_test();
  end
endmodule
`default_nettype wire
